// file: verilog/pst_telegram.sv
// Function
// - byte 12 bit 7 shows function A active or configured, default 0
// - byte 16 repeats the byte 12 layout for function B
// - flag bit 6 shows warning field, 0 violated, 1 free
// - flag bit 5 shows protective field, 0 violated, 1 free
// - flag bit 4 set while restart interlock active and start pending
// - flag bit 3 mirrors the safety output state, bits 2-0 reserved
// - byte 13 holds bank A high nibble, first pair low, 1 to 10
// - byte 14 holds second and third field pairs of function A
// - bytes 17 and 18 hold the same selections for function B
// - output byte bits 7 and 6 show warning segments 1 and 2
// - output byte bits 5 and 4 show protective segments 1 and 2
// - output byte bits 3 and 2 show defined field pair selected
// - bytes 8 to 11 hold a 32-bit scan count cleared at power-up (reset)
module pst_telegram (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic scan_done_in,
	input wire logic [4:0] byte_index_in,
	input wire logic func_a_active_in,
	input wire logic func_a_warn_field_state_in,
	input wire logic func_a_prot_field_state_in,
	input wire logic func_a_restart_interlock_in,
	input wire logic func_a_start_request_in,
	input wire logic func_a_safety_switching_output_in,
	input wire logic [3:0] func_a_bank_sel_in,
	input wire logic [3:0] func_a_pair1_sel_in,
	input wire logic [3:0] func_a_pair2_sel_in,
	input wire logic [3:0] func_a_pair3_sel_in,
	input wire logic func_a_warn_seg1_in,
	input wire logic func_a_warn_seg2_in,
	input wire logic func_a_prot_seg1_in,
	input wire logic func_a_prot_seg2_in,
	input wire logic func_a_defined_pair1_hit_in,
	input wire logic func_a_defined_pair2_hit_in,
	input wire logic func_b_active_in,
	input wire logic func_b_warn_field_state_in,
	input wire logic func_b_prot_field_state_in,
	input wire logic func_b_restart_interlock_in,
	input wire logic func_b_start_request_in,
	input wire logic func_b_safety_switching_output_in,
	input wire logic [3:0] func_b_bank_sel_in,
	input wire logic [3:0] func_b_pair1_sel_in,
	input wire logic [3:0] func_b_pair2_sel_in,
	input wire logic [3:0] func_b_pair3_sel_in,
	input wire logic func_b_warn_seg1_in,
	input wire logic func_b_warn_seg2_in,
	input wire logic func_b_prot_seg1_in,
	input wire logic func_b_prot_seg2_in,
	input wire logic func_b_defined_pair1_hit_in,
	input wire logic func_b_defined_pair2_hit_in,
	output logic [31:0] scan_count_out,
	output logic [7:0] byte_data_out
);

	// ----------------------------------------------------------------
	// per-function status bytes
	// ----------------------------------------------------------------
	logic [7:0] flag_a;
	logic [7:0] sel1_a;
	logic [7:0] sel2_a;
	logic [7:0] out_a;
	logic [7:0] flag_b;
	logic [7:0] sel1_b;
	logic [7:0] sel2_b;
	logic [7:0] out_b;

	// function A, bytes 12 to 15
	pst_func_status u_func_a (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.active_in(func_a_active_in),
		.warn_field_state_in(func_a_warn_field_state_in),
		.prot_field_state_in(func_a_prot_field_state_in),
		.restart_interlock_in(func_a_restart_interlock_in),
		.start_request_in(func_a_start_request_in),
		.safety_switching_output_in(func_a_safety_switching_output_in),
		.bank_sel_in(func_a_bank_sel_in),
		.pair1_sel_in(func_a_pair1_sel_in),
		.pair2_sel_in(func_a_pair2_sel_in),
		.pair3_sel_in(func_a_pair3_sel_in),
		.warn_seg1_in(func_a_warn_seg1_in),
		.warn_seg2_in(func_a_warn_seg2_in),
		.prot_seg1_in(func_a_prot_seg1_in),
		.prot_seg2_in(func_a_prot_seg2_in),
		.defined_pair1_hit_in(func_a_defined_pair1_hit_in),
		.defined_pair2_hit_in(func_a_defined_pair2_hit_in),
		.flag_byte_out(flag_a),
		.sel1_byte_out(sel1_a),
		.sel2_byte_out(sel2_a),
		.out_byte_out(out_a)
	);

	// function B, bytes 16 to 19, same layout
	pst_func_status u_func_b (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.active_in(func_b_active_in),
		.warn_field_state_in(func_b_warn_field_state_in),
		.prot_field_state_in(func_b_prot_field_state_in),
		.restart_interlock_in(func_b_restart_interlock_in),
		.start_request_in(func_b_start_request_in),
		.safety_switching_output_in(func_b_safety_switching_output_in),
		.bank_sel_in(func_b_bank_sel_in),
		.pair1_sel_in(func_b_pair1_sel_in),
		.pair2_sel_in(func_b_pair2_sel_in),
		.pair3_sel_in(func_b_pair3_sel_in),
		.warn_seg1_in(func_b_warn_seg1_in),
		.warn_seg2_in(func_b_warn_seg2_in),
		.prot_seg1_in(func_b_prot_seg1_in),
		.prot_seg2_in(func_b_prot_seg2_in),
		.defined_pair1_hit_in(func_b_defined_pair1_hit_in),
		.defined_pair2_hit_in(func_b_defined_pair2_hit_in),
		.flag_byte_out(flag_b),
		.sel1_byte_out(sel1_b),
		.sel2_byte_out(sel2_b),
		.out_byte_out(out_b)
	);

	// ----------------------------------------------------------------
	// scan counter
	// ----------------------------------------------------------------
	logic [31:0] scan_count_next;

	// wraps at the top; only reset (power-up) clears it
	assign scan_count_next = scan_done_in ? scan_count_out + 32'h0000_0001 : scan_count_out;

	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			scan_count_out <= pst_pkg::PST_SCAN_RESET;
		else
			scan_count_out <= scan_count_next;
	end

	// ----------------------------------------------------------------
	// byte selection for the telegram reader
	// ----------------------------------------------------------------
	logic [7:0] byte_data_next;
	logic [1:0] scan_lane;

	assign scan_lane = 2'(byte_index_in - pst_pkg::PST_SCAN_BYTE0);

	// bytes outside 8 to 19 read as zero; scan count little-endian
	always_comb
	begin
		byte_data_next = pst_pkg::PST_BYTE_RESET;
		if (byte_index_in >= pst_pkg::PST_SCAN_BYTE0 && byte_index_in <= pst_pkg::PST_SCAN_BYTE3)
			byte_data_next = scan_count_next[8*scan_lane +: 8];
		else
		begin
			unique case (byte_index_in)
				pst_pkg::PST_FLAG_A_BYTE: byte_data_next = flag_a;
				pst_pkg::PST_SEL1_A_BYTE: byte_data_next = sel1_a;
				pst_pkg::PST_SEL2_A_BYTE: byte_data_next = sel2_a;
				pst_pkg::PST_OUT_A_BYTE: byte_data_next = out_a;
				pst_pkg::PST_FLAG_B_BYTE: byte_data_next = flag_b;
				pst_pkg::PST_SEL1_B_BYTE: byte_data_next = sel1_b;
				pst_pkg::PST_SEL2_B_BYTE: byte_data_next = sel2_b;
				pst_pkg::PST_OUT_B_BYTE: byte_data_next = out_b;
				default: byte_data_next = pst_pkg::PST_BYTE_RESET;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
			byte_data_out <= pst_pkg::PST_BYTE_RESET;
		else
			byte_data_out <= byte_data_next;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// counter steps once per finished scan and holds otherwise
	scan_step_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		scan_done_in |=> scan_count_out == $past(scan_count_out) + 32'h0000_0001)
		else $error("scan count did not step");
	scan_hold_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		!scan_done_in |=> $stable(scan_count_out))
		else $error("scan count moved without scan");
	reset_clear_a: assert property (@(posedge sys_clk_in)
		!rst_n_in |=> scan_count_out == pst_pkg::PST_SCAN_RESET &&
		byte_data_out == pst_pkg::PST_BYTE_RESET)
		else $error("outputs not cleared by reset");

	// each status byte reaches the reader one edge after its index
	byte_a_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_FLAG_A_BYTE |=> byte_data_out == $past(flag_a))
		else $error("byte 12 does not carry function A flags");
	byte_a_sel1_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SEL1_A_BYTE |=> byte_data_out == $past(sel1_a))
		else $error("byte 13 does not carry function A bank");
	byte_a_sel2_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SEL2_A_BYTE |=> byte_data_out == $past(sel2_a))
		else $error("byte 14 does not carry function A pairs");
	byte_a_out_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_OUT_A_BYTE |=> byte_data_out == $past(out_a))
		else $error("byte 15 does not carry function A outputs");
	byte_b_flag_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_FLAG_B_BYTE |=> byte_data_out == $past(flag_b))
		else $error("byte 16 does not carry function B flags");
	byte_b_sel1_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SEL1_B_BYTE |=> byte_data_out == $past(sel1_b))
		else $error("byte 17 does not carry function B bank");
	byte_b_sel2_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SEL2_B_BYTE |=> byte_data_out == $past(sel2_b))
		else $error("byte 18 does not carry function B pairs");
	byte_b_segs_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_OUT_B_BYTE |=> byte_data_out == $past(out_b))
		else $error("byte 19 does not carry function B outputs");
	byte_out_b_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_OUT_B_BYTE |=> byte_data_out[1:0] == 2'h0)
		else $error("byte 19 reserved bits set");

	// scan lanes carry the fresh count, indices outside 8 to 19 read zero
	scan_low_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SCAN_BYTE0 |=> byte_data_out == scan_count_out[7:0])
		else $error("byte 8 is not the low count byte");
	scan_top_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		byte_index_in == pst_pkg::PST_SCAN_BYTE3 |=> byte_data_out == scan_count_out[31:24])
		else $error("byte 11 is not the top count byte");
	index_empty_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		(byte_index_in < pst_pkg::PST_SCAN_BYTE0 || byte_index_in > pst_pkg::PST_LAST_BYTE)
		|=> byte_data_out == pst_pkg::PST_BYTE_RESET)
		else $error("unused index does not read zero");

endmodule : pst_telegram

// file: verilog/pst_pkg.sv
package pst_pkg;

	// ----------------------------------------------------------------
	// byte offsets within the cyclic telegram
	// ----------------------------------------------------------------
	localparam logic [4:0] PST_SCAN_BYTE0 = 5'h08;
	localparam logic [4:0] PST_SCAN_BYTE3 = 5'h0b;
	localparam logic [4:0] PST_FLAG_A_BYTE = 5'h0c;
	localparam logic [4:0] PST_SEL1_A_BYTE = 5'h0d;
	localparam logic [4:0] PST_SEL2_A_BYTE = 5'h0e;
	localparam logic [4:0] PST_OUT_A_BYTE = 5'h0f;
	localparam logic [4:0] PST_FLAG_B_BYTE = 5'h10;
	localparam logic [4:0] PST_SEL1_B_BYTE = 5'h11;
	localparam logic [4:0] PST_SEL2_B_BYTE = 5'h12;
	localparam logic [4:0] PST_OUT_B_BYTE = 5'h13;
	localparam logic [4:0] PST_LAST_BYTE = 5'h13;

	// ----------------------------------------------------------------
	// bit positions within the flag and output bytes
	// ----------------------------------------------------------------
	localparam int PST_FLAG_ACTIVE_BIT = 7;
	localparam int PST_FLAG_WARN_BIT = 6;
	localparam int PST_FLAG_PROT_BIT = 5;
	localparam int PST_FLAG_RESTART_BIT = 4;
	localparam int PST_FLAG_SAFETY_BIT = 3;
	localparam int PST_OUT_WARN1_BIT = 7;
	localparam int PST_OUT_WARN2_BIT = 6;
	localparam int PST_OUT_PROT1_BIT = 5;
	localparam int PST_OUT_PROT2_BIT = 4;
	localparam int PST_OUT_PAIR1_BIT = 3;
	localparam int PST_OUT_PAIR2_BIT = 2;

	// ----------------------------------------------------------------
	// reset values and field limits
	// ----------------------------------------------------------------
	localparam logic [7:0] PST_BYTE_RESET = 8'h00;
	localparam logic [31:0] PST_SCAN_RESET = 32'h0000_0000;
	localparam logic [3:0] PST_SEL_MIN = 4'h1;
	localparam logic [3:0] PST_SEL_MAX = 4'ha;

endpackage : pst_pkg

// file: verilog/pst_func_status.sv
// ------------------------------------------------------------------
// status bytes of one protective function
// ------------------------------------------------------------------
module pst_func_status (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic active_in,
	input wire logic warn_field_state_in,
	input wire logic prot_field_state_in,
	input wire logic restart_interlock_in,
	input wire logic start_request_in,
	input wire logic safety_switching_output_in,
	input wire logic [3:0] bank_sel_in,
	input wire logic [3:0] pair1_sel_in,
	input wire logic [3:0] pair2_sel_in,
	input wire logic [3:0] pair3_sel_in,
	input wire logic warn_seg1_in,
	input wire logic warn_seg2_in,
	input wire logic prot_seg1_in,
	input wire logic prot_seg2_in,
	input wire logic defined_pair1_hit_in,
	input wire logic defined_pair2_hit_in,
	output logic [7:0] flag_byte_out,
	output logic [7:0] sel1_byte_out,
	output logic [7:0] sel2_byte_out,
	output logic [7:0] out_byte_out
);

	// ----------------------------------------------------------------
	// byte assembly
	// ----------------------------------------------------------------
	logic [7:0] flag_next;
	logic [7:0] sel1_next;
	logic [7:0] sel2_next;
	logic [7:0] out_next;
	logic restart_pending;

	// out-of-range selection numbers are sent as zero
	function automatic logic [3:0] pst_clip(input logic [3:0] v);
		if (v >= pst_pkg::PST_SEL_MIN && v <= pst_pkg::PST_SEL_MAX)
			return v;
		return 4'h0;
	endfunction : pst_clip

	assign restart_pending = restart_interlock_in & start_request_in;
	// flag byte, low three bits zero
	assign flag_next = {active_in, warn_field_state_in, prot_field_state_in,
		restart_pending, safety_switching_output_in, 3'h0};
	assign sel1_next = {pst_clip(bank_sel_in), pst_clip(pair1_sel_in)};
	assign sel2_next = {pst_clip(pair2_sel_in), pst_clip(pair3_sel_in)};
	assign out_next = {warn_seg1_in, warn_seg2_in, prot_seg1_in, prot_seg2_in,
		defined_pair1_hit_in, defined_pair2_hit_in, 2'h0};

	// registered bytes, zero after reset
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			flag_byte_out <= pst_pkg::PST_BYTE_RESET;
			sel1_byte_out <= pst_pkg::PST_BYTE_RESET;
			sel2_byte_out <= pst_pkg::PST_BYTE_RESET;
			out_byte_out <= pst_pkg::PST_BYTE_RESET;
		end
		else
		begin
			flag_byte_out <= flag_next;
			sel1_byte_out <= sel1_next;
			sel2_byte_out <= sel2_next;
			out_byte_out <= out_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// bits follow inputs one edge later; the edge leaving reset still shows zero
	flag_active_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> flag_byte_out[pst_pkg::PST_FLAG_ACTIVE_BIT] == $past(active_in))
		else $error("active bit does not follow input");
	restart_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> flag_byte_out[pst_pkg::PST_FLAG_RESTART_BIT] ==
		($past(restart_interlock_in) && $past(start_request_in)))
		else $error("restart bit wrong");
	warn_prot_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> flag_byte_out[6:5] ==
		{$past(warn_field_state_in), $past(prot_field_state_in)})
		else $error("field state bits wrong");
	safety_bit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |->
		flag_byte_out[pst_pkg::PST_FLAG_SAFETY_BIT] == $past(safety_switching_output_in))
		else $error("safety output bit lags");
	sel_range_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		sel1_byte_out[7:4] <= pst_pkg::PST_SEL_MAX &&
		sel1_byte_out[3:0] <= pst_pkg::PST_SEL_MAX &&
		sel2_byte_out[7:4] <= pst_pkg::PST_SEL_MAX &&
		sel2_byte_out[3:0] <= pst_pkg::PST_SEL_MAX)
		else $error("selection out of range");
	seg_bits_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		$past(rst_n_in) |-> out_byte_out[5:4] == {$past(prot_seg1_in), $past(prot_seg2_in)})
		else $error("protective segment bits wrong");
	reserved_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
		flag_byte_out[2:0] == 3'h0 && out_byte_out[1:0] == 2'h0)
		else $error("reserved bits not zero");

endmodule : pst_func_status

// file: verif/pst_host_model.sv
// ----------------------------------------------------------------
// host side that reads the telegram
// ----------------------------------------------------------------
module pst_host_model (
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic sweep_in,
	input wire logic [7:0] byte_data_in,
	output logic [4:0] byte_index_out,
	output logic rx_valid_out,
	output logic [4:0] rx_index_out,
	output logic [7:0] rx_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] index_d_reg;
	logic valid_d_reg;

	// walk the indices, pair each byte with the index that asked for it
	always_ff @(posedge sys_clk_in)
	begin
		if (!rst_n_in)
		begin
			byte_index_out <= 5'h00;
			index_d_reg <= 5'h00;
			valid_d_reg <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_index_out <= 5'h00;
			rx_data_out <= 8'h00;
		end
		else
		begin
			if (sweep_in)
				byte_index_out <= byte_index_out + 5'h01;
			index_d_reg <= byte_index_out; // answer lags the index by one edge
			valid_d_reg <= sweep_in;
			rx_valid_out <= valid_d_reg;
			rx_index_out <= index_d_reg;
			rx_data_out <= byte_data_in;
		end
	end
endmodule : pst_host_model

// file: verif/testbench.sv
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end
// ----------------------------------------------------------------
// self-checking bench for the status telegram
// ----------------------------------------------------------------
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk_in, rst_n_in, scan_done, sweep, rx_valid;
	logic [31:0] wa, wb, cnt, seed, scan_count;
	logic [4:0] byte_index, rx_index;
	logic [7:0] byte_data, rx_data, exp_byte;
	int failures = 0;
	int tests_run = 0;

	// stimulus word: [5:0] flags, [11:6] output bits, [27:12] nibbles
	pst_telegram pst_telegram_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.scan_done_in(scan_done), .byte_index_in(byte_index),
		.func_a_active_in(wa[0]), .func_a_warn_field_state_in(wa[1]),
		.func_a_prot_field_state_in(wa[2]), .func_a_restart_interlock_in(wa[3]),
		.func_a_start_request_in(wa[4]), .func_a_safety_switching_output_in(wa[5]),
		.func_a_bank_sel_in(wa[15:12]), .func_a_pair1_sel_in(wa[19:16]),
		.func_a_pair2_sel_in(wa[23:20]), .func_a_pair3_sel_in(wa[27:24]),
		.func_a_warn_seg1_in(wa[6]), .func_a_warn_seg2_in(wa[7]),
		.func_a_prot_seg1_in(wa[8]), .func_a_prot_seg2_in(wa[9]),
		.func_a_defined_pair1_hit_in(wa[10]), .func_a_defined_pair2_hit_in(wa[11]),
		.func_b_active_in(wb[0]), .func_b_warn_field_state_in(wb[1]),
		.func_b_prot_field_state_in(wb[2]), .func_b_restart_interlock_in(wb[3]),
		.func_b_start_request_in(wb[4]), .func_b_safety_switching_output_in(wb[5]),
		.func_b_bank_sel_in(wb[15:12]), .func_b_pair1_sel_in(wb[19:16]),
		.func_b_pair2_sel_in(wb[23:20]), .func_b_pair3_sel_in(wb[27:24]),
		.func_b_warn_seg1_in(wb[6]), .func_b_warn_seg2_in(wb[7]),
		.func_b_prot_seg1_in(wb[8]), .func_b_prot_seg2_in(wb[9]),
		.func_b_defined_pair1_hit_in(wb[10]), .func_b_defined_pair2_hit_in(wb[11]),
		.scan_count_out(scan_count), .byte_data_out(byte_data));

	pst_host_model pst_host_model_inst (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.sweep_in(sweep), .byte_data_in(byte_data), .byte_index_out(byte_index),
		.rx_valid_out(rx_valid), .rx_index_out(rx_index), .rx_data_out(rx_data));

	// ----------------------------------------------------------------
	// reference model
	// ----------------------------------------------------------------
	function automatic logic [31:0] pst_lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : pst_lfsr

	// selections outside 1..10 are sent as none
	function automatic logic [3:0] pst_nib(logic [3:0] v);
		return (v >= 4'h1 && v <= 4'ha) ? v : 4'h0;
	endfunction : pst_nib

	function automatic logic [7:0] pst_exp(logic [4:0] i, logic [31:0] a, b, c);
		logic [31:0] w;
		w = (i >= 5'h10) ? b : a;
		case (i)
			5'h08, 5'h09, 5'h0a, 5'h0b: return 8'(c >> (8 * (i - 5'h08)));
			5'h0c, 5'h10: return {w[0], w[1], w[2], w[3] & w[4], w[5], 3'h0};
			5'h0d, 5'h11: return {pst_nib(w[15:12]), pst_nib(w[19:16])};
			5'h0e, 5'h12: return {pst_nib(w[23:20]), pst_nib(w[27:24])};
			5'h0f, 5'h13: return {w[6], w[7], w[8], w[9], w[10], w[11], 2'h0};
			default: return 8'h00;
		endcase
	endfunction : pst_exp

	// ----------------------------------------------------------------
	// checking and run control
	// ----------------------------------------------------------------
	always #5 sys_clk_in = ~sys_clk_in;

	// every byte the host receives is held against the model
	always @(negedge sys_clk_in)
	begin
		if (rx_valid === 1'b1)
		begin
			exp_byte = pst_exp(rx_index, wa, wb, cnt);
			if (rx_index inside {[5'h08:5'h0b]})
				`CHECK(rx_data, exp_byte)
			else if (rx_index inside {[5'h0c:5'h0f]})
				`CHECK(rx_data, exp_byte)
			else if (rx_index inside {[5'h10:5'h13]})
				`CHECK(rx_data, exp_byte)
			else
				`CHECK(rx_data, exp_byte)
		end
	end

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out

	// host reads all 32 indices back to back
	task automatic run_sweep();
		@(posedge sys_clk_in) sweep <= 1'b1;
		repeat (32) @(posedge sys_clk_in);
		sweep <= 1'b0;
		repeat (3) @(posedge sys_clk_in);
	endtask : run_sweep

	initial
	begin
		repeat (20000) @(posedge sys_clk_in);
		failures++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		close_out();
	end

	initial
	begin
		sys_clk_in = 1'b0;
		rst_n_in = 1'b0;
		scan_done = 1'b0;
		sweep = 1'b0;
		wa = 32'h0;
		wb = 32'h0;
		cnt = 32'h0;
		seed = 32'h63a0;
		repeat (10) @(posedge sys_clk_in);
		@(negedge sys_clk_in) `CHECK(byte_data, 8'h00)
		repeat (10) @(posedge sys_clk_in);
		rst_n_in <= 1'b1;
		run_sweep();
		// two directed boundary patterns, then random ones
		for (int it = 0; it < 24; it++)
		begin
			seed = pst_lfsr(pst_lfsr(pst_lfsr(seed)));
			@(posedge sys_clk_in);
			wa <= (it == 0) ? 32'h0aaa_afff : (it == 1) ? 32'h0111_1000 : seed;
			wb <= (it == 0) ? 32'h0bbb_b000 : (it == 1) ? 32'h0fff_f015 : ~seed;
			if (seed[1:0] != 2'h0)
			begin
				scan_done <= 1'b1;
				repeat (seed[1:0]) @(posedge sys_clk_in);
				scan_done <= 1'b0;
				cnt = cnt + 32'(seed[1:0]);
			end
			repeat (3) @(posedge sys_clk_in);
			@(negedge sys_clk_in) `CHECK(scan_count, cnt)
			run_sweep();
		end
		// power cycle clears the scan count
		@(posedge sys_clk_in) rst_n_in <= 1'b0;
		repeat (2) @(posedge sys_clk_in);
		@(negedge sys_clk_in) `CHECK(scan_count, 32'h0)
		cnt = 32'h0;
		@(posedge sys_clk_in) rst_n_in <= 1'b1;
		run_sweep();
		close_out();
	end
endmodule : testbench
